// ---- dv/sipm_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module sipm_far_end (
    input  wire logic       frame_in,
    input  wire logic [1:0] code_in,
    input  wire logic       rxd_val_in,
    output logic            link_clk_out,
    output logic            rxd_out,
    output logic            sync_hi_out,
    output logic            sync_lo_out
);
    // Link clock stands low between frames
    initial begin
        link_clk_out = 1'b0;
        #5;
        forever begin
            #32;
            link_clk_out = frame_in & ~link_clk_out;
        end
    end
    // Idle data line shows the inverse, never a stale bit
    assign rxd_out     = frame_in ? rxd_val_in : ~rxd_val_in;
    assign sync_hi_out = code_in[1];
    assign sync_lo_out = code_in[0];
endmodule : sipm_far_end
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sipm_pkg::*;
;
    logic       clk_sys_in = 1'b0, rst_n_in = 1'b0;
    sipm_mode_t ch1_mode_in = SIPM_NONMULTIPLEXED_MODE, ch2_mode_in = SIPM_NONMULTIPLEXED_MODE;
    logic [7:0] pa_dedicated_in = 8'h00, pa_gpio_dir_in = 8'h00;
    logic [7:0] pa_gpio_out_in = 8'h00, pa_pin_in = 8'h00, v, g;
    logic [5:0] pcm_route_in = 6'h39;
    logic [2:0] scc_txd_in = 3'h0, exp_word = 3'h0, rx_word_out;
    logic [1:0] strobe_mask_in = 2'h0, code = 2'h2;
    logic       txd_open_drain_in = 0, ch1_ext_clk_in = 0, ch1_clk_drive_in = 1;
    logic       rclk_tristate_in = 0, tclk_tristate_in = 0, cd_auto_in = 0;
    logic       baud_one_disable_in = 0, cd_alt_func_in = 0, cts_abort_en_in = 0;
    logic       strobe_two_en_in = 0, ch2_clk_drive_in = 0, ch1_brg_in = 0;
    logic       ch2_brg_in = 0, ch1_tx_pending_in = 0, ch2_rts_n_in = 1;
    logic       l1_request_in = 0, gci_dclk_in = 0, b1_slot_in = 0, b2_slot_in = 0;
    logic       cts_pin_n_in = 1, rx_ready_in = 0, frame = 0, rxd_val = 0;
    wire logic  rxd_pin_in, rclk_pin_in, tclk_pin_in, cd_pin_n_in;
    logic       txd_pin_out, txd_pin_oe_out, rclk_pin_out, rclk_pin_oe_out;
    logic       tclk_pin_out, tclk_pin_oe_out, rts_pin_n_out, baud_one_out;
    logic [7:0] pa_pin_out, pa_pin_oe_out, pa_level_out;
    logic       ch1_cd_out, cd_level_out, cts_level_out, cd_event_out;
    logic       cd_irq_out, cts_event_out, cts_abort_out, l1_sync_out;
    logic       l1_grant_out, ch2_rxd_out, ch2_cts_out, ch2_cd_out;
    logic       rx_valid_out, rx_overrun_out;
    logic[20:0] r;
    int         fail_count = 0, checked = 0, pops = 0, p0, ovr = 0;
    int         cd_ev = 0, cd_irq = 0, seed = 93933;

    sipm_top uut (.*);
    sipm_far_end far (.frame_in(frame), .code_in(code), .rxd_val_in(rxd_val),
        .link_clk_out(rclk_pin_in), .rxd_out(rxd_pin_in),
        .sync_hi_out(cd_pin_n_in), .sync_lo_out(tclk_pin_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] ex, got);
        checked++;
        if (got !== ex) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : step
    // Frames start and stop on a system edge, length in link periods
    task automatic run_frame(input int n);
        @(posedge clk_sys_in) frame <= 1'b1;
        #(n * 64);
        @(posedge clk_sys_in) frame <= 1'b0;
        step(8);
    endtask : run_frame
    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #100000;
        fail_count++;
        test_done();
    end
    always @(posedge clk_sys_in) begin
        ovr <= ovr + rx_overrun_out;
        cd_ev <= cd_ev + cd_event_out;
        cd_irq <= cd_irq + cd_irq_out;
        if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1) begin
            pops <= pops + 1;
            chk("rx_word", exp_word, rx_word_out);
        end
    end
    initial begin
        step(15);
        chk("oe_rst", 0, {txd_pin_oe_out, rclk_pin_oe_out, tclk_pin_oe_out});
        @(posedge clk_sys_in) rst_n_in <= 1'b1;
        step(3);
        chk("rclk_oe", 1, rclk_pin_oe_out);
        chk("tclk_oe", 1, tclk_pin_oe_out);
        @(posedge clk_sys_in) {rclk_tristate_in, tclk_tristate_in} <= 2'h3;
        {ch1_tx_pending_in, baud_one_disable_in, ch1_brg_in} <= 3'h7;
        step(2);
        chk("rclk_ts", 0, rclk_pin_oe_out);
        chk("tclk_ts", 0, tclk_pin_oe_out);
        chk("rts", 0, rts_pin_n_out);
        chk("baud_dis", 1, baud_one_out);
        // Clock outputs off before the source changes
        @(posedge clk_sys_in) ch1_clk_drive_in <= 1'b0;
        {rclk_tristate_in, tclk_tristate_in} <= 2'h0;
        @(posedge clk_sys_in) ch1_ext_clk_in <= 1'b1;
        {ch1_tx_pending_in, baud_one_disable_in} <= 2'h0;
        step(2);
        chk("rclk_ext", 0, rclk_pin_oe_out);
        chk("rts_idle", 1, rts_pin_n_out);
        chk("baud_inv", 0, baud_one_out);
        @(posedge clk_sys_in) code <= 2'h0;
        step(4);
        run_frame(3);
        chk("cd_ev", 1, 8'(cd_ev));
        chk("cd_irq", 1, 8'(cd_irq));
        chk("cd_lvl", 1, cd_level_out);
        chk("ch1_cd", 1, ch1_cd_out);
        @(posedge clk_sys_in) cd_alt_func_in <= 1'b1;
        ch1_mode_in <= SIPM_GCI;
        step(2);
        chk("cd_alt", 0, ch1_cd_out);
        chk("gci_dcl", gci_dclk_in, rts_pin_n_out);
        chk("sds_oe", 1, tclk_pin_oe_out);
        chk("l1_sync", 1, l1_sync_out);
        chk("l1_grant", 0, l1_grant_out);
        @(posedge clk_sys_in) ch1_mode_in <= SIPM_IDL;
        step(2);
        chk("idl_txd", 1, txd_pin_oe_out);
        // Bit seven dedicated strobe, the rest GPIO
        for (int i = 0; i < 8; i++) begin
            r = 21'($random(seed));
            v = 8'($random(seed));
            g = r[7:0] ^ v;
            @(posedge clk_sys_in) {pa_pin_in, scc_txd_in, strobe_mask_in} <= r[12:0];
            {b1_slot_in, b2_slot_in, l1_request_in, ch2_brg_in} <= r[16:13];
            {ch2_rts_n_in, txd_open_drain_in, strobe_two_en_in} <= r[19:17];
            {ch2_clk_drive_in, ch1_brg_in} <= {r[20], v[0]};
            {pa_gpio_dir_in, pa_gpio_out_in, pa_dedicated_in} <= {v | 8'h80, g, 8'h80};
            step(2);
            chk("baud", {7'h0, ~v[0]}, baud_one_out);
            chk("pa_oe", v | 8'h80, pa_pin_oe_out);
            g = {r[15] & r[1], g[6:0] & v[6:0]};
            chk("pa_out", g, pa_pin_out & (v | 8'h80));
            chk("pa_lvl", r[12:5], pa_level_out);
        end
        @(posedge clk_sys_in) {rst_n_in, cd_alt_func_in} <= 2'h0;
        ch1_mode_in <= SIPM_PCM;
        step(3);
        @(posedge clk_sys_in) {rst_n_in, rx_ready_in} <= 2'h3;
        step(6);
        chk("pcm_idle", 0, txd_pin_oe_out);
        chk("pcm_sync", 0, tclk_pin_oe_out);
        p0 = pops;
        run_frame(3);
        chk("idle_pops", 0, 8'(pops - p0));
        @(posedge clk_sys_in) {code, rx_ready_in, rxd_val} <= {3'h4, v[1]};
        exp_word <= {2'h2, v[1]};
        step(6);
        run_frame(20);
        chk("overrun", 1, ovr > 0);
        p0 = pops;
        @(posedge clk_sys_in) rx_ready_in <= 1'b1;
        step(40);
        chk("drain", 16, 8'(pops - p0));
        chk("empty", 0, rx_valid_out);
        @(posedge clk_sys_in) {code, rxd_val} <= {2'h1, ~v[1]};
        exp_word <= {2'h1, ~v[1]};
        step(6);
        p0 = pops;
        run_frame(3);
        chk("ch1_pops", 1, pops > p0);
        test_done();
    end
endmodule : tb_top
`default_nettype wire

// ---- pkg/sipm_params.svh ----
// Function
// - First port pins follow the active mode
// - Transmit data open-drain or three-state per mode
// - Receive clock pin direction follows clock source
// - Tristate bits silence receive and transmit clocks
// - Transmit clock pin: clock, sync, or strobe
// - PCM sync pair decodes idle or channel
// - PCM channels routed to controllers by mode
// - Strobes mark masked B1/B2 slots
// - Carrier change over one receive clock flagged
// - Carrier usable as interrupt, level always readable
// - Carrier forced low under alternate function
// - Clear-to-send change flagged, optional frame abort
// - Request-to-send asserted while data pending
// - Request pin is request or clock; grant input
// - Baud pin carries inverted baud clock
// - Baud disable bit drives the pin high
// - Second port pins individually GPIO or dedicated
// - Port bit seven is strobe or baud clock
// - Dedicated use of bit seven overrides its GPIO output
// - Baud clock pin placement depends on mode
// - Baud clock optionally on clock pins
`ifndef SIPM_PARAMS_SVH
`define SIPM_PARAMS_SVH
`define SIPM_SYNC_IDLE 2'h0
`define SIPM_SYNC_CH1  2'h1
`define SIPM_SYNC_CH2  2'h2
`define SIPM_SYNC_CH3  2'h3
`define SIPM_ROUTE_SERIAL_CHANNEL_ONE 2'h1
`define SIPM_CHG_EDGES 2'h1
`define SIPM_FIFO_DEPTH 16
`define SIPM_FIFO_WIDTH 3
`define SIPM_PA_RXD  0
`define SIPM_PA_TXD  1
`define SIPM_PA_RCLK 2
`define SIPM_PA_TCLK 3
`define SIPM_PA_CTS  4
`define SIPM_PA_RTS  5
`define SIPM_PA_CD   6
`define SIPM_PA_SDS  7
`define SIPM_NSYNC   13
`endif

// ---- pkg/sipm_pkg.sv ----
package sipm_pkg;
    typedef enum logic [3:0] {
        SIPM_NONMULTIPLEXED_MODE = 4'h1,
        SIPM_GCI  = 4'h2,
        SIPM_IDL  = 4'h4,
        SIPM_PCM  = 4'h8
    } sipm_mode_t;

    typedef struct packed {
        logic       txd, txd_oe, rclk, rclk_oe, tclk, tclk_oe;
        logic       rts_n, baud1;
        logic [7:0] pa_o, pa_oe;
        logic       ch1_cd, l1_sync, l1_grant;
        logic       ch2_rxd, ch2_cts, ch2_cd;
        logic       rx_prev, tx_prev, cd_stable, cts_stable;
        logic [1:0] cd_cnt, cts_cnt, route;
        logic       cd_evt, cd_irq, cts_evt, cts_abort, overrun;
    } sipm_state_t;

    localparam sipm_state_t SIPM_STATE_RST = '{rts_n: 1'b1, baud1: 1'b1,
        cd_stable: 1'b1, cts_stable: 1'b1, default: '0};
endpackage : sipm_pkg

// ---- rtl/sipm_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sipm_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic      [WIDTH-1:0] out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wptr, rptr;
    } sipm_fifo_st_t;
    sipm_fifo_st_t s_reg, s_next;
    logic full, empty;

    assign empty = (s_reg.wptr == s_reg.rptr);
    assign full  = (s_reg.wptr[AW-1:0] == s_reg.rptr[AW-1:0]) &&
                   (s_reg.wptr[AW] != s_reg.rptr[AW]);
    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = s_reg.mem[s_reg.rptr[AW-1:0]];

    always_comb begin
        s_next = s_reg;
        if (in_valid_in && !full) begin
            s_next.mem[s_reg.wptr[AW-1:0]] = in_data_in;
            s_next.wptr = s_reg.wptr + 1'b1;
        end
        if (out_ready_in && !empty) s_next.rptr = s_reg.rptr + 1'b1;
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) s_reg <= '0;
        else           s_reg <= s_next;
    end

    property p_no_over;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        full |=> (s_reg.wptr == $past(s_reg.wptr)) || !$stable(s_reg.rptr);
    endproperty
    a_no_over: assert property (p_no_over)
        else $error("fifo written while full");
endmodule : sipm_fifo
`default_nettype wire

// ---- rtl/sipm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module sipm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first, second;
    } sipm_sync_st_t;
    sipm_sync_st_t s_reg, s_next;

    // First stage feeds only the second stage
    always_comb begin
        s_next.first  = async_in;
        s_next.second = s_reg.first;
    end
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) s_reg <= '0;
        else           s_reg <= s_next;
    end
    assign sync_out = s_reg.second;
endmodule : sipm_sync
`default_nettype wire

// ---- rtl/sipm_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sipm_params.svh"
module sipm_top
    import sipm_pkg::*;
#(
    parameter int FIFO_WIDTH = `SIPM_FIFO_WIDTH,
    parameter int FIFO_DEPTH = `SIPM_FIFO_DEPTH
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    // Mode and pin selection
    input  wire sipm_mode_t       ch1_mode_in,
    input  wire sipm_mode_t       ch2_mode_in,
    input  wire logic [7:0]       pa_dedicated_in,
    input  wire logic [7:0]       pa_gpio_dir_in,
    input  wire logic [7:0]       pa_gpio_out_in,
    // Configuration bits
    input  wire logic             txd_open_drain_in,
    input  wire logic             ch1_ext_clk_in,
    input  wire logic             ch1_clk_drive_in,
    input  wire logic             rclk_tristate_in,
    input  wire logic             tclk_tristate_in,
    input  wire logic             baud_one_disable_in,
    input  wire logic             cd_alt_func_in,
    input  wire logic             cd_auto_in,
    input  wire logic             cts_abort_en_in,
    input  wire logic [5:0]       pcm_route_in,
    input  wire logic [1:0]       strobe_mask_in,
    input  wire logic             strobe_two_en_in,
    input  wire logic             ch2_clk_drive_in,
    // Serial controller side
    input  wire logic [2:0]       scc_txd_in,
    input  wire logic             ch1_brg_in,
    input  wire logic             ch2_brg_in,
    input  wire logic             ch1_tx_pending_in,
    input  wire logic             ch2_rts_n_in,
    input  wire logic             l1_request_in,
    input  wire logic             gci_dclk_in,
    input  wire logic             b1_slot_in,
    input  wire logic             b2_slot_in,
    // First port pins
    input  wire logic             rxd_pin_in,
    output logic                  txd_pin_out,
    output logic                  txd_pin_oe_out,
    input  wire logic             rclk_pin_in,
    output logic                  rclk_pin_out,
    output logic                  rclk_pin_oe_out,
    input  wire logic             tclk_pin_in,
    output logic                  tclk_pin_out,
    output logic                  tclk_pin_oe_out,
    input  wire logic             cd_pin_n_in,
    input  wire logic             cts_pin_n_in,
    output logic                  rts_pin_n_out,
    output logic                  baud_one_out,
    // Second port pins
    input  wire logic [7:0]       pa_pin_in,
    output logic      [7:0]       pa_pin_out,
    output logic      [7:0]       pa_pin_oe_out,
    output logic      [7:0]       pa_level_out,
    // Internal results
    output logic                  ch1_cd_out,
    output logic                  cd_level_out,
    output logic                  cts_level_out,
    output logic                  cd_event_out,
    output logic                  cd_irq_out,
    output logic                  cts_event_out,
    output logic                  cts_abort_out,
    output logic                  l1_sync_out,
    output logic                  l1_grant_out,
    output logic                  ch2_rxd_out,
    output logic                  ch2_cts_out,
    output logic                  ch2_cd_out,
    output logic [FIFO_WIDTH-1:0] rx_word_out,
    output logic                  rx_valid_out,
    input  wire logic             rx_ready_in,
    output logic                  rx_overrun_out
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [`SIPM_NSYNC-1:0] raw, syn;
    logic rxd_s, rclk_s, tclk_s, cd_s, cts_s;
    logic [7:0] pa_s;
    assign raw = {pa_pin_in, rxd_pin_in, rclk_pin_in, tclk_pin_in,
                  cd_pin_n_in, cts_pin_n_in};
    assign {pa_s, rxd_s, rclk_s, tclk_s, cd_s, cts_s} = syn;

    sipm_sync #(.WIDTH(`SIPM_NSYNC)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .async_in   (raw),
        .sync_out   (syn)
    );

    ////////////////////////////////////////////////////////////////////
    // Receive buffer
    sipm_state_t s_reg, s_next;
    logic push, fifo_ready;
    logic [FIFO_WIDTH-1:0] push_word;

    sipm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys_in    (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_data_in    (push_word),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .out_data_out  (rx_word_out),
        .out_valid_out (rx_valid_out),
        .out_ready_in  (rx_ready_in)
    );

    ////////////////////////////////////////////////////////////////////
    // Mode decode and routing
    logic nonmultiplexed_mode, gci, idl, pcm, l1strobe, brg_on_pins;
    logic rx_clk, tx_clk, rx_edge, tx_edge;
    logic [1:0] sync_code, route;
    logic data_strobe_one, data_strobe_two, pcm_idle, txd_d;

    always_comb begin
        nonmultiplexed_mode = (ch1_mode_in == SIPM_NONMULTIPLEXED_MODE);
        gci  = (ch1_mode_in == SIPM_GCI);
        idl  = (ch1_mode_in == SIPM_IDL);
        pcm  = (ch1_mode_in == SIPM_PCM);
        l1strobe = gci || idl;
        brg_on_pins = nonmultiplexed_mode && !ch1_ext_clk_in && ch1_clk_drive_in;
        // Layer-1 clock feeds both directions when multiplexed
        rx_clk = brg_on_pins ? ch1_brg_in : rclk_s;
        tx_clk = !nonmultiplexed_mode ? rclk_s : (brg_on_pins ? ch1_brg_in : tclk_s);
        rx_edge = rx_clk && !s_reg.rx_prev;
        tx_edge = tx_clk && !s_reg.tx_prev;
        sync_code = {cd_s, tclk_s};
        pcm_idle = pcm && (sync_code == `SIPM_SYNC_IDLE);
        case (sync_code)
            `SIPM_SYNC_CH1: route = pcm_route_in[1:0];
            `SIPM_SYNC_CH2: route = pcm_route_in[3:2];
            `SIPM_SYNC_CH3: route = pcm_route_in[5:4];
            default:        route = `SIPM_ROUTE_SERIAL_CHANNEL_ONE;
        endcase
        if (!pcm) route = `SIPM_ROUTE_SERIAL_CHANNEL_ONE;
        // Route code 0 means no controller owns the slot
        txd_d = (route == 2'h0) ? 1'b1 : scc_txd_in[route - 2'h1];
        data_strobe_one = b1_slot_in && strobe_mask_in[0];
        data_strobe_two = b2_slot_in && strobe_mask_in[1];
        push = rx_edge && !pcm_idle && (route != 2'h0);
        push_word = {route, rxd_s};
    end

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.rx_prev = rx_clk;
        s_next.tx_prev = tx_clk;
        s_next.route   = route;
        s_next.overrun = push && !fifo_ready;

        // Transmit data pin
        s_next.txd = txd_d;
        if (gci || (nonmultiplexed_mode && txd_open_drain_in)) begin
            s_next.txd    = 1'b0;
            s_next.txd_oe = !txd_d;
        end else begin
            s_next.txd_oe = !pcm_idle;
        end

        // Receive clock pin
        s_next.rclk    = ch1_brg_in;
        s_next.rclk_oe = brg_on_pins && !rclk_tristate_in;

        // Transmit clock pin
        if (l1strobe) begin
            s_next.tclk    = data_strobe_one;
            s_next.tclk_oe = 1'b1;
        end else begin
            s_next.tclk    = ch1_brg_in;
            s_next.tclk_oe = brg_on_pins && !tclk_tristate_in;
        end

        // Request pin
        case (ch1_mode_in)
            SIPM_NONMULTIPLEXED_MODE: s_next.rts_n = !ch1_tx_pending_in;
            SIPM_IDL:  s_next.rts_n = !l1_request_in;
            SIPM_GCI:  s_next.rts_n = gci_dclk_in;
            SIPM_PCM:  s_next.rts_n = !(ch1_tx_pending_in && !pcm_idle);
            default:   s_next.rts_n = 1'b1;
        endcase

        // Baud pin is the inverse phase of the clock pins
        s_next.baud1 = baud_one_disable_in ? 1'b1 : !ch1_brg_in;

        // Layer-1 sync and grant
        s_next.l1_sync  = l1strobe && !cd_s;
        s_next.l1_grant = l1strobe && !cts_s;
        s_next.ch1_cd   = (nonmultiplexed_mode && !cd_alt_func_in) ? !cd_s : 1'b0;

        // Carrier change must survive a full receive clock
        s_next.cd_evt = 1'b0;
        s_next.cd_irq = 1'b0;
        if (cd_s == s_reg.cd_stable) begin
            s_next.cd_cnt = 2'h0;
        end else if (rx_edge && nonmultiplexed_mode) begin
            if (s_reg.cd_cnt == `SIPM_CHG_EDGES) begin
                s_next.cd_stable = cd_s;
                s_next.cd_cnt    = 2'h0;
                s_next.cd_evt    = 1'b1;
                s_next.cd_irq    = !cd_auto_in;
            end else begin
                s_next.cd_cnt = s_reg.cd_cnt + 2'h1;
            end
        end

        // Same filter for clear-to-send on the transmit clock
        s_next.cts_evt   = 1'b0;
        s_next.cts_abort = 1'b0;
        if (cts_s == s_reg.cts_stable) begin
            s_next.cts_cnt = 2'h0;
        end else if (tx_edge && nonmultiplexed_mode) begin
            if (s_reg.cts_cnt == `SIPM_CHG_EDGES) begin
                s_next.cts_stable = cts_s;
                s_next.cts_cnt    = 2'h0;
                s_next.cts_evt    = 1'b1;
                s_next.cts_abort  = cts_abort_en_in && cts_s &&
                                    ch1_tx_pending_in;
            end else begin
                s_next.cts_cnt = s_reg.cts_cnt + 2'h1;
            end
        end

        // Second port, dedicated pins mirror the first port
        s_next.ch2_rxd = pa_dedicated_in[`SIPM_PA_RXD] && pa_s[`SIPM_PA_RXD];
        s_next.ch2_cts = pa_dedicated_in[`SIPM_PA_CTS] && !pa_s[`SIPM_PA_CTS];
        s_next.ch2_cd  = pa_dedicated_in[`SIPM_PA_CD] && !pa_s[`SIPM_PA_CD];
    end

    ////////////////////////////////////////////////////////////////////
    // Second port pin drivers
    logic [7:0] ded_o, ded_oe;
    always_comb begin
        ded_o  = '0;
        ded_oe = '0;
        ded_o[`SIPM_PA_TXD]  = scc_txd_in[1];
        ded_oe[`SIPM_PA_TXD] = 1'b1;
        ded_o[`SIPM_PA_RTS]  = ch2_rts_n_in;
        ded_oe[`SIPM_PA_RTS] = 1'b1;
        ded_o[`SIPM_PA_RCLK] = ch2_brg_in;
        ded_o[`SIPM_PA_TCLK] = ch2_brg_in;
        if (ch2_mode_in == SIPM_NONMULTIPLEXED_MODE) begin
            ded_oe[`SIPM_PA_RCLK] = ch2_clk_drive_in;
            ded_oe[`SIPM_PA_TCLK] = ch2_clk_drive_in;
        end else begin
            ded_oe[`SIPM_PA_TCLK] = 1'b1;
        end
        // Bit seven: strobe in GCI/IDL or with strobe two enabled on a non-multiplexed second channel, else baud clock
        if (l1strobe || (ch2_mode_in == SIPM_NONMULTIPLEXED_MODE && strobe_two_en_in)) begin
            ded_o[`SIPM_PA_SDS] = data_strobe_two;
        end else begin
            ded_o[`SIPM_PA_SDS] = !ch2_brg_in;
        end
        ded_oe[`SIPM_PA_SDS] = l1strobe || (ch2_mode_in == SIPM_NONMULTIPLEXED_MODE);
    end

    logic [7:0] s_next_pa_o, s_next_pa_oe;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pa
            // Dedicated selection wins, so GPIO settings are ignored on a dedicated pin
            always_comb begin
                if (pa_dedicated_in[gi]) begin
                    s_next_pa_o[gi]  = ded_o[gi];
                    s_next_pa_oe[gi] = ded_oe[gi];
                end else begin
                    s_next_pa_o[gi]  = pa_gpio_out_in[gi];
                    s_next_pa_oe[gi] = pa_gpio_dir_in[gi];
                end
            end
        end
    endgenerate

    sipm_state_t s_full;
    always_comb begin
        s_full       = s_next;
        s_full.pa_o  = s_next_pa_o;
        s_full.pa_oe = s_next_pa_oe;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) s_reg <= SIPM_STATE_RST;
        else           s_reg <= s_full;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign txd_pin_out     = s_reg.txd;
    assign txd_pin_oe_out  = s_reg.txd_oe;
    assign rclk_pin_out    = s_reg.rclk;
    assign rclk_pin_oe_out = s_reg.rclk_oe;
    assign tclk_pin_out    = s_reg.tclk;
    assign tclk_pin_oe_out = s_reg.tclk_oe;
    assign rts_pin_n_out   = s_reg.rts_n;
    assign baud_one_out    = s_reg.baud1;
    assign pa_pin_out      = s_reg.pa_o;
    assign pa_pin_oe_out   = s_reg.pa_oe;
    assign pa_level_out    = pa_s;
    assign ch1_cd_out      = s_reg.ch1_cd;
    assign cd_level_out    = !s_reg.cd_stable;
    assign cts_level_out   = !s_reg.cts_stable;
    assign cd_event_out    = s_reg.cd_evt;
    assign cd_irq_out      = s_reg.cd_irq;
    assign cts_event_out   = s_reg.cts_evt;
    assign cts_abort_out   = s_reg.cts_abort;
    assign l1_sync_out     = s_reg.l1_sync;
    assign l1_grant_out    = s_reg.l1_grant;
    assign ch2_rxd_out     = s_reg.ch2_rxd;
    assign ch2_cts_out     = s_reg.ch2_cts;
    assign ch2_cd_out      = s_reg.ch2_cd;
    assign rx_overrun_out  = s_reg.overrun;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    property p_baud_off;
        baud_one_disable_in |=> baud_one_out;
    endproperty
    a_baud_off: assert property (p_baud_off)
        else $error("baud pin not high while disabled");

    property p_baud_inv;
        !baud_one_disable_in |=> (baud_one_out == !$past(ch1_brg_in));
    endproperty
    a_baud_inv: assert property (p_baud_inv)
        else $error("baud pin not inverted clock");

    property p_gci_od;
        (ch1_mode_in == SIPM_GCI) |=> !(txd_pin_oe_out && txd_pin_out);
    endproperty
    a_gci_od: assert property (p_gci_od)
        else $error("transmit data drives high in open-drain mode");

    property p_pcm_idle;
        pcm_idle |=> !txd_pin_oe_out;
    endproperty
    a_pcm_idle: assert property (p_pcm_idle)
        else $error("transmit data driven in idle sync code");

    property p_rclk_tri;
        (rclk_tristate_in || !nonmultiplexed_mode) |=> !rclk_pin_oe_out;
    endproperty
    a_rclk_tri: assert property (p_rclk_tri)
        else $error("receive clock driven when it must be input");

    property p_tclk_pcm;
        pcm |=> !tclk_pin_oe_out;
    endproperty
    a_tclk_pcm: assert property (p_tclk_pcm)
        else $error("transmit clock driven in PCM mode");

    property p_cd_ground;
        cd_alt_func_in |=> !ch1_cd_out;
    endproperty
    a_cd_ground: assert property (p_cd_ground)
        else $error("internal carrier not grounded");

    property p_cd_pulse;
        cd_event_out |=> !cd_event_out [*2];
    endproperty
    a_cd_pulse: assert property (p_cd_pulse)
        else $error("carrier event repeats too soon");

    property p_rts;
        (nonmultiplexed_mode && ch1_tx_pending_in) |=> !rts_pin_n_out;
    endproperty
    a_rts: assert property (p_rts)
        else $error("request to send not asserted");

    property p_pa_gpio;
        !pa_dedicated_in[`SIPM_PA_SDS] |=>
            (pa_pin_oe_out[`SIPM_PA_SDS] ==
             $past(pa_gpio_dir_in[`SIPM_PA_SDS]));
    endproperty
    a_pa_gpio: assert property (p_pa_gpio)
        else $error("bit seven not under GPIO control");
endmodule : sipm_top
`default_nettype wire
